// >>> verilog/nio_top.sv
// Three nibble I/O ports behind an APB slave, with pseudo serial output on port A.
// Assumes a 125 MHz pclk, pins already synchronous, and an APB3 master.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module nio_top
  import nio_pkg::*;
#(
  parameter logic [3:0] A_IO_MASK = 4'hf,
  parameter logic [3:0] B_IO_MASK = 4'hf,
  parameter logic [3:0] C_IO_MASK = 4'hf,
  parameter bit         A_PULL    = 1'b1,
  parameter bit         B_PULL    = 1'b1,
  parameter bit         C_PULL    = 1'b1,
  parameter bit         C_HOLD    = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  port_a_in,
  output logic      [3:0]  port_a_out,
  output logic      [3:0]  port_a_oe,
  output logic      [3:0]  port_a_pull_en,
  input  wire logic [3:0]  port_b_in,
  output logic      [3:0]  port_b_out,
  output logic      [3:0]  port_b_oe,
  output logic      [3:0]  port_b_pull_en,
  input  wire logic [3:0]  port_c_in,
  output logic      [3:0]  port_c_out,
  output logic      [3:0]  port_c_oe,
  output logic      [3:0]  port_c_pull_en,
  output logic      [3:0]  port_c_hold_en
);

  // ------------------------------------------------------------
  // Build-time checks
  // ------------------------------------------------------------
  if (NIO_W != 4) begin : g_bad_width
    $error("Ports must be four bits wide.");
  end
  if (PULSE_CYC < 1 || PULSE_CYC >= (1 << PULSE_CNT_W)) begin : g_bad_pulse
    $error("Serial pulse length does not fit its counter.");
  end
  if (C_HOLD && !C_PULL) begin : g_bad_c_hold
    $error("Port C low-level hold needs the port C pull-low device.");
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire setup_rd  = psel & ~penable & ~pwrite;
  wire access_wr = psel & penable & pwrite;

  wire hit_a_cfg  = (paddr == OFS_A_CFG);
  wire hit_a_wr   = (paddr == OFS_A_WR);
  wire hit_a_rd   = (paddr == OFS_A_RD);
  wire hit_b_cfg  = (paddr == OFS_B_CFG);
  wire hit_b_wr   = (paddr == OFS_B_WR);
  wire hit_b_rd   = (paddr == OFS_B_RD);
  wire hit_c_cfg  = (paddr == OFS_C_CFG);
  wire hit_c_wr   = (paddr == OFS_C_WR);
  wire hit_c_rd   = (paddr == OFS_C_RD);
  wire hit_ser    = (paddr == OFS_SER);
  wire hit_status = (paddr == OFS_STATUS);

  wire hit_any = hit_a_cfg | hit_a_wr | hit_a_rd | hit_b_cfg | hit_b_wr | hit_b_rd
               | hit_c_cfg | hit_c_wr | hit_c_rd | hit_ser | hit_status;

  wire we_a_cfg = access_wr & hit_a_cfg;
  wire we_a_wr  = access_wr & hit_a_wr;
  wire we_b_cfg = access_wr & hit_b_cfg;
  wire we_b_wr  = access_wr & hit_b_wr;
  wire we_c_cfg = access_wr & hit_c_cfg;
  wire we_c_wr  = access_wr & hit_c_wr;

  // Zero wait states: every access completes in its first access cycle.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // ------------------------------------------------------------
  // Port slices
  // ------------------------------------------------------------
  nio_port_if if_a ();
  nio_port_if if_b ();
  nio_port_if if_c ();

  assign if_a.cfg_we = we_a_cfg;
  assign if_a.wr_we  = we_a_wr;
  assign if_a.wdata  = pwdata[4:0];
  assign if_b.cfg_we = we_b_cfg;
  assign if_b.wr_we  = we_b_wr;
  assign if_b.wdata  = pwdata[4:0];
  assign if_b.ovr_en   = 1'b0;
  assign if_b.ovr_data = 4'h0;
  assign if_c.cfg_we = we_c_cfg;
  assign if_c.wr_we  = we_c_wr;
  assign if_c.wdata  = pwdata[4:0];
  assign if_c.ovr_en   = 1'b0;
  assign if_c.ovr_data = 4'h0;

  // Port A masked pins belong to the LCD drive or oscillator functions.
  nio_port #(
    .IO_MASK  (A_IO_MASK),
    .HAS_PULL (A_PULL),
    .HAS_HOLD (1'b0)
  ) u_port_a (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (if_a.port),
    .pin_in  (port_a_in),
    .pin_out (port_a_out),
    .pin_oe  (port_a_oe),
    .pull_en (port_a_pull_en),
    .hold_en ()
  );

  nio_port #(
    .IO_MASK  (B_IO_MASK),
    .HAS_PULL (B_PULL),
    .HAS_HOLD (1'b0)
  ) u_port_b (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (if_b.port),
    .pin_in  (port_b_in),
    .pin_out (port_b_out),
    .pin_oe  (port_b_oe),
    .pull_en (port_b_pull_en),
    .hold_en ()
  );

  // Port C masked pins serve as key-scan inputs outside this block.
  nio_port #(
    .IO_MASK  (C_IO_MASK),
    .HAS_PULL (C_PULL),
    .HAS_HOLD (C_HOLD)
  ) u_port_c (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (if_c.port),
    .pin_in  (port_c_in),
    .pin_out (port_c_out),
    .pin_oe  (port_c_oe),
    .pull_en (port_c_pull_en),
    .hold_en (port_c_hold_en)
  );

  // ------------------------------------------------------------
  // Pseudo serial output on port A
  // ------------------------------------------------------------
  nio_ser_e                 ser_state;
  nio_ser_e                 next_ser_state;
  logic [2:0]               ser_bits;
  logic [2:0]               next_ser_bits;
  logic [PULSE_CNT_W-1:0]   pulse_cnt;
  logic [PULSE_CNT_W-1:0]   next_pulse_cnt;

  wire ser_we    = access_wr & hit_ser;
  wire ser_const = pwdata[SER_CONST_BIT];
  wire pulse_on  = (pulse_cnt != '0);

  always_comb begin
    next_ser_state = ser_state;
    unique case (ser_state)
      NIO_SER_OFF: begin
        if (ser_we && ser_const) begin
          next_ser_state = NIO_SER_ON;
        end
      end
      NIO_SER_ON: begin
        if (ser_we && !ser_const) begin
          next_ser_state = NIO_SER_OFF;
        end
      end
    endcase
  end

  // Every serial write, the closing one included, issues one strobe pulse.
  assign next_pulse_cnt = ser_we  ? PULSE_CNT_W'(PULSE_CYC) :
                          pulse_on ? pulse_cnt - 1'b1 : pulse_cnt;

  assign next_ser_bits = ser_we ? {ser_const, pwdata[1:0]} : ser_bits;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_state <= NIO_SER_OFF;
    end else begin
      ser_state <= next_ser_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= '0;
    end else begin
      pulse_cnt <= next_pulse_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_bits <= SER_RESET;
    end else begin
      ser_bits <= next_ser_bits;
    end
  end

  // The override only reaches pins already set as outputs, so software must
  // configure port A as output first; otherwise nothing appears.
  assign if_a.ovr_en   = (ser_state == NIO_SER_ON) | pulse_on;
  assign if_a.ovr_data = {pulse_on, ser_bits};

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  function automatic logic [31:0] nib_word(input logic [3:0] nib);
    return {28'h0, nib};
  endfunction

  function automatic logic [31:0] cfg_word(input logic pull, input logic [3:0] dir);
    logic [31:0] word;
    word               = nib_word(dir);
    word[CFG_PULL_BIT] = pull;
    return word;
  endfunction

  function automatic logic [31:0] status_word(input logic ser_on, input logic pulse);
    logic [31:0] word;
    word                = 32'h0;
    word[STS_SER_BIT]   = ser_on;
    word[STS_PULSE_BIT] = pulse;
    return word;
  endfunction

  function automatic logic [31:0] pick(input logic hit, input logic [31:0] word);
    return hit ? word : 32'h0;
  endfunction

  // The hits are one-hot, so a plain AND-OR select needs no priority order.
  wire [31:0] word_a_cfg  = cfg_word(if_a.pull_ctl, if_a.dir);
  wire [31:0] word_a_wr   = nib_word(if_a.latch);
  wire [31:0] word_a_rd   = nib_word(if_a.rd_data);
  wire [31:0] word_b_cfg  = cfg_word(if_b.pull_ctl, if_b.dir);
  wire [31:0] word_b_wr   = nib_word(if_b.latch);
  wire [31:0] word_b_rd   = nib_word(if_b.rd_data);
  wire [31:0] word_c_cfg  = cfg_word(if_c.pull_ctl, if_c.dir);
  wire [31:0] word_c_wr   = nib_word(if_c.latch);
  wire [31:0] word_c_rd   = nib_word(if_c.rd_data);
  wire [31:0] word_ser    = nib_word({pulse_on, ser_bits});
  wire [31:0] word_status = status_word(ser_state == NIO_SER_ON, pulse_on);

  wire [31:0] next_prdata = pick(hit_a_cfg, word_a_cfg)
                          | pick(hit_a_wr, word_a_wr)
                          | pick(hit_a_rd, word_a_rd)
                          | pick(hit_b_cfg, word_b_cfg)
                          | pick(hit_b_wr, word_b_wr)
                          | pick(hit_b_rd, word_b_rd)
                          | pick(hit_c_cfg, word_c_cfg)
                          | pick(hit_c_wr, word_c_wr)
                          | pick(hit_c_rd, word_c_rd)
                          | pick(hit_ser, word_ser)
                          | pick(hit_status, word_status);

  // Pins are sampled in the setup cycle so the value is stable through access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup_rd) begin
      prdata <= next_prdata;
    end
  end

endmodule

// >>> verilog/nio_pkg.sv
// Constants shared by the nibble I/O port block and its port slice.
// Assumes a single 125 MHz APB clock domain.
package nio_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int NIO_W      = 4;
  localparam int NIO_ADDR_W = 8;
  localparam int NIO_DATA_W = 32;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_A_CFG  = 8'h00;
  localparam logic [7:0] OFS_A_WR   = 8'h04;
  localparam logic [7:0] OFS_A_RD   = 8'h08;
  localparam logic [7:0] OFS_B_CFG  = 8'h10;
  localparam logic [7:0] OFS_B_WR   = 8'h14;
  localparam logic [7:0] OFS_B_RD   = 8'h18;
  localparam logic [7:0] OFS_C_CFG  = 8'h20;
  localparam logic [7:0] OFS_C_WR   = 8'h24;
  localparam logic [7:0] OFS_C_RD   = 8'h28;
  localparam logic [7:0] OFS_SER    = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG_PULL_BIT  = 4;
  localparam int SER_CONST_BIT = 2;
  localparam int SER_PULSE_BIT = 3;
  localparam int STS_SER_BIT   = 0;
  localparam int STS_PULSE_BIT = 1;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [3:0] DIR_RESET   = 4'h0;
  localparam logic [3:0] LATCH_RESET = 4'h0;
  localparam logic       PULL_RESET  = 1'b1;
  localparam logic [2:0] SER_RESET   = 3'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int PULSE_NS      = 16;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W   = 4;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic {
    NIO_SER_OFF = 1'b0,
    NIO_SER_ON  = 1'b1
  } nio_ser_e;

endpackage

// >>> verilog/nio_port_if.sv
// Carrier between the register front end and one 4-bit port slice.
// Assumes both ends share the APB clock.
`timescale 1ns/1ps
interface nio_port_if;
  logic       cfg_we;
  logic       wr_we;
  logic [4:0] wdata;
  logic       ovr_en;
  logic [3:0] ovr_data;
  logic [3:0] dir;
  logic [3:0] latch;
  logic       pull_ctl;
  logic [3:0] rd_data;

  modport ctrl (
    output cfg_we,
    output wr_we,
    output wdata,
    output ovr_en,
    output ovr_data,
    input  dir,
    input  latch,
    input  pull_ctl,
    input  rd_data
  );

  modport port (
    input  cfg_we,
    input  wr_we,
    input  wdata,
    input  ovr_en,
    input  ovr_data,
    output dir,
    output latch,
    output pull_ctl,
    output rd_data
  );
endinterface

// >>> verilog/nio_port.sv
// One 4-bit general-purpose port: direction, output latch, pull control.
// Assumes pins are synchronous to pclk and the controller pulses the strobes.
`timescale 1ns/1ps
module nio_port
  import nio_pkg::*;
#(
  parameter logic [3:0] IO_MASK  = 4'hf,
  parameter bit         HAS_PULL = 1'b1,
  parameter bit         HAS_HOLD = 1'b0
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  nio_port_if.port   bus,
  input  wire logic [3:0] pin_in,
  output logic      [3:0] pin_out,
  output logic      [3:0] pin_oe,
  output logic      [3:0] pull_en,
  output logic      [3:0] hold_en
);

  // ------------------------------------------------------------
  // Build-time checks
  // ------------------------------------------------------------
  if (HAS_HOLD && !HAS_PULL) begin : g_bad_hold
    $error("Low-level hold needs the pull-low device on this port.");
  end

  logic [3:0] dir;
  logic [3:0] latch;
  logic       pull_ctl;

  // ------------------------------------------------------------
  // Control state
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir      <= DIR_RESET;
      latch    <= LATCH_RESET;
      pull_ctl <= PULL_RESET;
    end else begin
      if (bus.cfg_we) begin
        dir      <= bus.wdata[3:0] & IO_MASK;
        pull_ctl <= bus.wdata[CFG_PULL_BIT];
      end
      if (bus.wr_we) begin
        latch <= bus.wdata[3:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Pin side
  // ------------------------------------------------------------
  wire [3:0] drive_val = bus.ovr_en ? bus.ovr_data : latch;
  wire [3:0] in_mode   = ~dir & IO_MASK;

  assign pin_out = drive_val & dir & IO_MASK;
  assign pin_oe  = dir & IO_MASK;
  // Pull and hold are never on for an output bit, so the driver never fights them.
  assign pull_en = (HAS_PULL && pull_ctl) ? in_mode : 4'h0;
  assign hold_en = (HAS_HOLD && !pull_ctl) ? in_mode : 4'h0;
  assign bus.rd_data = ((dir & latch) | (~dir & pin_in)) & IO_MASK;

  assign bus.dir      = dir;
  assign bus.latch    = latch;
  assign bus.pull_ctl = pull_ctl;

endmodule

// >>> test/nio_top_monitor.sv
// Checker for the nibble port block, watching only its top-level ports.
// Assumes one pclk domain and the default port A and C io masks.
`timescale 1ns/1ps
module nio_top_monitor
  import nio_pkg::*;
#(
  parameter logic [3:0] B_IO_MASK = 4'hf
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [3:0]  port_a_out,
  input wire logic [3:0]  port_a_oe,
  input wire logic [3:0]  port_a_pull_en,
  input wire logic [3:0]  port_b_in,
  input wire logic [3:0]  port_b_out,
  input wire logic [3:0]  port_b_oe,
  input wire logic [3:0]  port_c_oe,
  input wire logic [3:0]  port_c_pull_en,
  input wire logic [3:0]  port_c_hold_en
);
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr     = psel && penable && pwrite;
  wire wr_ser = wr && paddr == OFS_SER;
  wire rd_b   = psel && !penable && !pwrite && paddr == OFS_B_RD;
  wire c_cfg  = wr && paddr == OFS_C_CFG;

  // A back-to-back serial write at the last pulse cycle restarts the pulse.
  sequence s_pulse;
    port_a_out[3] ##1 port_a_out[3] ##1 (!port_a_out[3] || $past(wr_ser));
  endsequence
  sequence s_ser_on;
    wr_ser && pwdata[2] && port_a_oe == 4'hf;
  endsequence

  property p_rst_dir; $rose(presetn) |-> (port_a_oe | port_b_oe | port_c_oe) == 4'h0; endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("port not input after reset");
  property p_rst_c; $rose(presetn) |-> port_c_pull_en == 4'hf && port_c_hold_en == 4'h0; endproperty
  a_rst_c: assert property (p_rst_c) else $error("port c pull state wrong after reset");
  property p_dir; (wr && paddr == OFS_A_CFG) |=> port_a_oe == $past(pwdata[3:0]); endproperty
  a_dir: assert property (p_dir) else $error("direction not taken");
  property p_pull; (wr && paddr == OFS_A_CFG && !pwdata[4]) |=> port_a_pull_en == 4'h0; endproperty
  a_pull: assert property (p_pull) else $error("pull-low not disabled");
  property p_latch;
    (wr && paddr == OFS_B_WR) |=> port_b_out == ($past(pwdata[3:0]) & port_b_oe);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not driven on outputs");
  property p_read;
    rd_b |=> prdata[3:0] == (($past(port_b_in) & ~$past(port_b_oe) & B_IO_MASK)
                             | ($past(port_b_out) & $past(port_b_oe)));
  endproperty
  a_read: assert property (p_read) else $error("read value wrong");
  property p_c_on; (c_cfg && pwdata[4:0] == 5'h10) |=> port_c_pull_en == 4'hf && !port_c_hold_en; endproperty
  a_c_on: assert property (p_c_on) else $error("pull-low not selected");
  property p_c_off; (c_cfg && pwdata[4:0] == 5'h00) |=> !port_c_pull_en && port_c_hold_en == 4'hf; endproperty
  a_c_off: assert property (p_c_off) else $error("hold not selected");
  property p_c_out; |port_c_oe |-> (port_c_oe & (port_c_pull_en | port_c_hold_en)) == 4'h0; endproperty
  a_c_out: assert property (p_c_out) else $error("pull or hold on an output bit");
  property p_ser; s_ser_on |=> port_a_out[2:0] == $past(pwdata[2:0]) and s_pulse; endproperty
  a_ser: assert property (p_ser) else $error("serial word or pulse wrong");
endmodule

bind nio_top nio_top_monitor #(.B_IO_MASK(B_IO_MASK)) i_nio_top_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .port_a_out(port_a_out),
  .port_a_oe(port_a_oe), .port_a_pull_en(port_a_pull_en), .port_b_in(port_b_in),
  .port_b_out(port_b_out), .port_b_oe(port_b_oe), .port_c_oe(port_c_oe),
  .port_c_pull_en(port_c_pull_en), .port_c_hold_en(port_c_hold_en)
);

// >>> test/nio_pin_model.sv
// Circuitry hanging on one 4-bit port: drivers, pull-low and hold loads.
// Output enable overrides ext_en and ext_val, so the bench may keep them set while the port is output.
`timescale 1ns/1ps
module nio_pin_model (
  input  wire logic       pclk,
  input  wire logic [3:0] oe,
  input  wire logic [3:0] out,
  input  wire logic [3:0] pull_en,
  input  wire logic [3:0] hold_en,
  input  wire logic [3:0] ext_en,
  input  wire logic [3:0] ext_val,
  output logic      [3:0] level
);
  logic [3:0] prev = 4'h0;
  // A floating pin toggles every cycle so a stale value can never pass.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (oe[i]) level[i] = out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pull_en[i] || hold_en[i]) level[i] = 1'b0;
      else level[i] = ~prev[i];
    end
  end
  always @(posedge pclk) prev <= level;
endmodule

// >>> test/nio_top_test.sv
// Self-checking bench for the nibble port block over APB.
// Assumes the checker is bound in and pin models stand on every port.
`timescale 1ns/1ps
module nio_top_test
  import nio_pkg::*;
;
  localparam logic [3:0] BM = 4'h7;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, rerr;
  logic [3:0]  port_a_in, port_a_out, port_a_oe, port_a_pull_en, port_b_in, port_b_out;
  logic [3:0]  port_b_oe, port_b_pull_en, port_c_in, port_c_out, port_c_oe, port_c_pull_en;
  logic [3:0]  port_c_hold_en;
  logic [3:0]  ext_en [3] = '{4'h0, 4'hf, 4'h0};
  logic [3:0]  ext_val [3] = '{4'h0, 4'h5, 4'h0};
  int          failures = 0, num_checks = 0;

  // ----------------------------------------------------------
  // Design and pin models
  // ----------------------------------------------------------
  nio_top #(.B_IO_MASK(BM)) i_nio_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_in(port_a_in), .port_a_out(port_a_out),
    .port_a_oe(port_a_oe), .port_a_pull_en(port_a_pull_en), .port_b_in(port_b_in),
    .port_b_out(port_b_out), .port_b_oe(port_b_oe), .port_b_pull_en(port_b_pull_en),
    .port_c_in(port_c_in), .port_c_out(port_c_out), .port_c_oe(port_c_oe),
    .port_c_pull_en(port_c_pull_en), .port_c_hold_en(port_c_hold_en));
  nio_pin_model i_nio_pin_model_a (.pclk(pclk), .oe(port_a_oe), .out(port_a_out),
    .pull_en(port_a_pull_en), .hold_en(4'h0), .ext_en(ext_en[0]), .ext_val(ext_val[0]),
    .level(port_a_in));
  nio_pin_model i_nio_pin_model_b (.pclk(pclk), .oe(port_b_oe), .out(port_b_out),
    .pull_en(port_b_pull_en), .hold_en(4'h0), .ext_en(ext_en[1]), .ext_val(ext_val[1]),
    .level(port_b_in));
  nio_pin_model i_nio_pin_model_c (.pclk(pclk), .oe(port_c_oe), .out(port_c_out),
    .pull_en(port_c_pull_en), .hold_en(port_c_hold_en), .ext_en(ext_en[2]),
    .ext_val(ext_val[2]), .level(port_c_in));

  initial forever #4 pclk = ~pclk;

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  // Returns just after the completing edge, so outputs have settled.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) failures++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    chk(port_a_oe | port_b_oe | port_c_oe, 4'h0);
    chk(port_b_pull_en, BM);
    chk(port_c_pull_en, 4'hf);
    chk(port_c_hold_en, 4'h0);
    apb(1'b0, OFS_A_CFG, 32'h0);
    chk(rdata, 32'h10);
    $display("reset test done");
  endtask
  task automatic t_port_b();
    apb(1'b1, OFS_B_WR, 32'ha);
    apb(1'b1, OFS_B_CFG, 32'h1f);
    chk(port_b_oe, BM);
    chk(port_b_out, 4'ha & BM);
    chk(port_b_pull_en, 4'h0);
    apb(1'b1, OFS_B_CFG, 32'h13);
    chk(port_b_oe, 4'h3);
    chk(port_b_pull_en, 4'h4 & BM);
    apb(1'b0, OFS_B_RD, 32'h0);
    chk(rdata, {28'h0, (4'ha & 4'h3) | (4'h5 & ~4'h3 & BM)});
    $display("port b test done");
  endtask
  task automatic t_port_c();
    apb(1'b1, OFS_C_CFG, 32'h00);
    chk({port_c_pull_en, port_c_hold_en}, 8'h0f);
    apb(1'b1, OFS_C_CFG, 32'h10);
    chk({port_c_pull_en, port_c_hold_en}, 8'hf0);
    apb(1'b1, OFS_C_WR, 32'h9);
    apb(1'b1, OFS_C_CFG, 32'h03);
    chk(port_c_out, 4'h1);
    chk({port_c_pull_en, port_c_hold_en}, 8'h0c);
    apb(1'b0, OFS_C_RD, 32'h0);
    chk(rdata, 32'h1);
    $display("port c test done");
  endtask
  task automatic t_serial();
    apb(1'b1, OFS_A_WR, 32'h0);
    apb(1'b1, OFS_A_CFG, 32'h0f);
    chk(port_a_pull_en, 4'h0);
    apb(1'b1, OFS_SER, 32'h5);
    chk(port_a_out, 4'hd);
    tick(PULSE_CYC);
    chk(port_a_out, 4'h5);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdata[1:0], 2'b01);
    apb(1'b1, OFS_SER, 32'h2);
    chk(port_a_out, 4'ha);
    tick(PULSE_CYC);
    chk(port_a_out, 4'h0);
    $display("serial test done");
  endtask
  task automatic t_unmapped();
    apb(1'b0, 8'h3c, 32'h0);
    chk(rerr, 1'b1);
    chk(rdata, 32'h0);
    $display("unmapped test done");
  endtask
  task automatic t_osc_pin();
    apb(1'b1, OFS_A_WR, 32'h2);
    apb(1'b1, OFS_A_CFG, 32'h12);
    chk(port_a_oe, 4'h2);
    chk(port_a_pull_en, 4'hd);
    apb(1'b1, OFS_A_WR, 32'h3);
    chk(port_a_out, 4'h2);
    apb(1'b0, OFS_A_RD, 32'h0);
    chk(rdata, 32'h2);
    $display("oscillator pin test done");
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_reset();
    t_port_b();
    t_port_c();
    t_serial();
    t_osc_pin();
    t_unmapped();
    give_verdict();
  end
  initial begin
    repeat (2000) @(posedge pclk);
    failures++;
    give_verdict();
  end
endmodule
